// ==== design/ccd_core.sv ====
// calibration coefficient decoder: register file, operand decode and correction datapath
//
// Register access over AXI4-Lite and the address map were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module ccd_core (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [ccd_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [ccd_pkg::AXI_DW-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ccd_pkg::AXI_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [ccd_pkg::AXI_DW-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [ccd_pkg::RAW_W-1:0] bridgeRawReading,
  input wire logic [ccd_pkg::RAW_W-1:0] tempRawReading,
  input wire logic rawValid,
  output ccd_pkg::ccd_result_t corrected,
  output logic correctedValid
);
  import ccd_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  // bus slave state
  logic awReady_ff, wReady_ff, bValid_ff, arReady_ff, rValid_ff;
  logic [1:0] bResp_ff, rResp_ff;
  logic [AXI_AW-1:0] awAddr_ff;
  logic [AXI_DW-1:0] wData_ff, rData_ff;
  logic [3:0] wStrb_ff;
  logic [AXI_DW-1:0] coefWord_ff [NUM_COEF];
  logic [AXI_DW-1:0] nxt_coefWord [NUM_COEF];
  logic [NUM_CLIP-1:0] statFlag_ff;
  ccd_result_t result_ff;
  logic resultValid_ff;
  wire logic awTake = s_axi_awvalid & awReady_ff;
  wire logic wTake = s_axi_wvalid & wReady_ff;
  // both halves held and no response pending: commit now
  wire logic doWrite = ~awReady_ff & ~wReady_ff & ~bValid_ff;
  wire logic bDone = bValid_ff & s_axi_bready;
  wire logic arTake = s_axi_arvalid & arReady_ff;
  wire logic rDone = rValid_ff & s_axi_rready;
  wire logic [5:0] wIdx = awAddr_ff[AXI_AW-1:2];
  wire logic [5:0] rIdx = s_axi_araddr[AXI_AW-1:2];
  wire logic wIsCoef = wIdx < 6'(NUM_COEF);
  wire logic wIsStat = wIdx == REG_STATUS[AXI_AW-1:2];
  wire logic [AXI_DW-1:0] strbMask = {{8{wStrb_ff[3]}}, {8{wStrb_ff[2]}},
                                      {8{wStrb_ff[1]}}, {8{wStrb_ff[0]}}};
  wire logic [NUM_CLIP-1:0] statClear = (doWrite & wIsStat) ?
                                        (wData_ff[NUM_CLIP-1:0] & strbMask[NUM_CLIP-1:0]) : '0;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      awReady_ff <= 1'b1;
      awAddr_ff <= '0;
    end else if (awTake) begin
      awReady_ff <= 1'b0;
      awAddr_ff <= s_axi_awaddr;
    end else if (bDone) begin
      awReady_ff <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wReady_ff <= 1'b1;
      wData_ff <= '0;
      wStrb_ff <= '0;
    end else if (wTake) begin
      wReady_ff <= 1'b0;
      wData_ff <= s_axi_wdata;
      wStrb_ff <= s_axi_wstrb;
    end else if (bDone) begin
      wReady_ff <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bValid_ff <= 1'b0;
      bResp_ff <= RESP_OKAY;
    end else if (doWrite) begin
      bValid_ff <= 1'b1;
      bResp_ff <= (wIsCoef | wIsStat) ? RESP_OKAY : RESP_SLVERR;
    end else if (bDone) begin
      bValid_ff <= 1'b0;
    end
  end
  // coefficient words, reserved bits forced to zero
  for (genvar gi = 0; gi < NUM_COEF; gi++) begin : g_coef
    assign nxt_coefWord[gi] = ((coefWord_ff[gi] & ~strbMask) | (wData_ff & strbMask)) &
                              COEF_MASK[gi];
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        coefWord_ff[gi] <= COEF_RESET;
      end else if (doWrite && wIdx == 6'(gi)) begin
        coefWord_ff[gi] <= nxt_coefWord[gi];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // coefficient fields as written by the calibration host
  ccd_coef_t coef;
  assign coef.gainB = coefWord_ff[0][GAINB_W-1:0];
  assign coef.offB = coefWord_ff[1][OFFB_W-1:0];
  assign coef.offBSign = coefWord_ff[1][OFFB_SIGN_BIT];
  assign coef.gainT = coefWord_ff[2][GAINT_LSB +: COEF8_W];
  assign coef.offT = coefWord_ff[2][OFFT_LSB +: COEF8_W];
  assign coef.refTemp = coefWord_ff[2][REFT_LSB +: REFT_W];
  assign coef.tcoMag = coefWord_ff[3][TCO_LSB +: COEF8_W];
  assign coef.tcgMag = coefWord_ff[3][TCG_LSB +: COEF8_W];
  assign coef.driftCfg = coefWord_ff[3][DCFG_LSB +: 3];
  assign coef.sotCoef = coefWord_ff[4][SOT_LSB +: COEF8_W];
  assign coef.sotSel = coefWord_ff[4][SEL_LSB +: 2];
  ////////////////////////////////////////////////////////////////////////////
  // operand decode
  // gain in units of 2^-11; scale bit shifts the fraction up three places
  wire logic [GAIN_DEC_W-1:0] gainDec = coef.gainB[GAINB_SCALE_BIT] ?
      {coef.gainB[GAINB_SCALE_BIT-1:0], {GAINB_SCALE_SH{1'b0}}} :
      {{GAINB_SCALE_SH{1'b0}}, coef.gainB[GAINB_SCALE_BIT-1:0]};
  wire logic signed [16:0] offDec = 17'($signed({coef.offBSign, coef.offB}));
  wire logic [RAW_W-1:0] tempQ = {tempRawReading[RAW_W-1:TEMP_STEP_SH],
                                  {TEMP_STEP_SH{1'b0}}};
  wire logic signed [31:0] deltaT = 32'($signed({1'b0, tempRawReading[RAW_W-1:REFT_SH]})) -
                                    32'($signed({1'b0, coef.refTemp}));
  logic signed [SCALED_W-1:0] tcoS, tcgS, sotS;
  // only the offset-drift target inherits the times-eight scale
  wire logic sotScale = (coef.sotSel == SOT_TO_TCO) & coef.driftCfg[DRIFT_TCO_SCALE];
  ccd_sm_scale u_tco (
    .negative(coef.driftCfg[DRIFT_TCO_SIGN]),
    .magnitude(coef.tcoMag),
    .scaleBy8(coef.driftCfg[DRIFT_TCO_SCALE]),
    .value(tcoS)
  );
  ccd_sm_scale u_tcg (
    .negative(coef.driftCfg[DRIFT_TCG_SIGN]),
    .magnitude(coef.tcgMag),
    .scaleBy8(1'b0),
    .value(tcgS)
  );
  ccd_sm_scale u_sot (
    .negative(coef.sotCoef[SOT_MAG_W]),
    .magnitude({1'b0, coef.sotCoef[SOT_MAG_W-1:0]}),
    .scaleBy8(sotScale),
    .value(sotS)
  );
  // code 11 is prohibited: the term then reaches no target
  wire logic signed [SCALED_W-1:0] sotBridge = (coef.sotSel == SOT_TO_BRIDGE) ? sotS : '0;
  wire logic signed [SCALED_W-1:0] sotTcg = (coef.sotSel == SOT_TO_TCG) ? sotS : '0;
  wire logic signed [SCALED_W-1:0] sotTco = (coef.sotSel == SOT_TO_TCO) ? sotS : '0;
  ////////////////////////////////////////////////////////////////////////////
  // correction datapath, widths sized for the largest products
  logic [NUM_CLIP-1:0] clipNow;
  logic [RAW_W-1:0] linB, bridgeCorr, tempCorr;
  logic [DRIFT_W-1:0] offDrift, gainDrift;
  wire logic signed [16:0] sumB = $signed({3'h0, bridgeRawReading}) + offDec;
  wire logic signed [39:0] prodB = 40'(sumB) * 40'($signed({1'b0, gainDec}));
  wire logic signed [39:0] scaledB = prodB >>> GAINB_FRAC;
  ccd_sat #(.IN_W(40), .OUT_W(RAW_W), .UNS(1'b1)) u_satLin (
    .din(scaledB),
    .dout(linB),
    .clipped(clipNow[0])
  );
  wire logic [27:0] nlSq = 28'(linB) * 28'(linB);
  wire logic [RAW_W-1:0] nlS = nlSq[27:NL_SH];
  wire logic signed [27:0] termB = 28'($signed({1'b0, nlS})) * 28'(sotBridge);
  wire logic signed [27:0] nlSum = 28'($signed({1'b0, linB})) + (termB >>> SOT_BR_SH);
  // a strong negative curve pins at zero instead of wrapping to full scale
  ccd_sat #(.IN_W(28), .OUT_W(RAW_W), .UNS(1'b1)) u_satBr (
    .din(nlSum),
    .dout(bridgeCorr),
    .clipped(clipNow[1])
  );
  wire logic [21:0] tProd = 22'(tempQ) * 22'(coef.gainT);
  wire logic signed [23:0] tSum = 24'($signed({1'b0, tProd[21:GAINT_FRAC]})) +
                                  24'($signed(coef.offT));
  ccd_sat #(.IN_W(24), .OUT_W(RAW_W), .UNS(1'b1)) u_satT (
    .din(tSum),
    .dout(tempCorr),
    .clipped(clipNow[2])
  );
  wire logic signed [31:0] offDriftRaw = 32'(tcoS) * deltaT + 32'(sotTco) * deltaT * deltaT;
  wire logic signed [31:0] gainDriftRaw = 32'(tcgS) * deltaT + 32'(sotTcg) * deltaT * deltaT;
  ccd_sat #(.IN_W(32), .OUT_W(DRIFT_W), .UNS(1'b0)) u_satOd (
    .din(offDriftRaw),
    .dout(offDrift),
    .clipped(clipNow[3])
  );
  ccd_sat #(.IN_W(32), .OUT_W(DRIFT_W), .UNS(1'b0)) u_satGd (
    .din(gainDriftRaw),
    .dout(gainDrift),
    .clipped(clipNow[4])
  );
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      result_ff <= '0;
      resultValid_ff <= 1'b0;
    end else begin
      resultValid_ff <= rawValid;
      if (rawValid) begin
        result_ff <= '{bridgeCorr, tempCorr, offDrift, gainDrift};
      end
    end
  end
  // sticky clip flags, a new clip wins over a same-cycle clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      statFlag_ff <= STAT_RESET;
    end else begin
      statFlag_ff <= (statFlag_ff & ~statClear) | (rawValid ? clipNow : '0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read path, one cycle after the address is taken
  wire logic [AXI_DW-1:0] rdMux =
      (rIdx < 6'(NUM_COEF)) ? coefWord_ff[rIdx[2:0]] :
      (rIdx == REG_STATUS[AXI_AW-1:2]) ? {{(AXI_DW - NUM_CLIP){1'b0}}, statFlag_ff} :
      (rIdx == REG_BRIDGE_OUT[AXI_AW-1:2]) ? {{(AXI_DW - RAW_W){1'b0}}, result_ff.bridgeCorr} :
      (rIdx == REG_TEMP_OUT[AXI_AW-1:2]) ? {{(AXI_DW - RAW_W){1'b0}}, result_ff.tempCorr} :
      (rIdx == REG_OFF_DRIFT[AXI_AW-1:2]) ? {{(AXI_DW - DRIFT_W){1'b0}}, result_ff.offDrift} :
      (rIdx == REG_GAIN_DRIFT[AXI_AW-1:2]) ? {{(AXI_DW - DRIFT_W){1'b0}}, result_ff.gainDrift} :
      '0;
  wire logic rMapped = rIdx <= REG_GAIN_DRIFT[AXI_AW-1:2];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      arReady_ff <= 1'b1;
      rValid_ff <= 1'b0;
      rData_ff <= '0;
      rResp_ff <= RESP_OKAY;
    end else if (arTake) begin
      arReady_ff <= 1'b0;
      rValid_ff <= 1'b1;
      rData_ff <= rdMux;
      rResp_ff <= rMapped ? RESP_OKAY : RESP_SLVERR;
    end else if (rDone) begin
      arReady_ff <= 1'b1;
      rValid_ff <= 1'b0;
    end
  end
  assign s_axi_awready = awReady_ff;
  assign s_axi_wready = wReady_ff;
  assign s_axi_bvalid = bValid_ff;
  assign s_axi_bresp = bResp_ff;
  assign s_axi_arready = arReady_ff;
  assign s_axi_rvalid = rValid_ff;
  assign s_axi_rdata = rData_ff;
  assign s_axi_rresp = rResp_ff;
  assign corrected = result_ff;
  assign correctedValid = resultValid_ff;
  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire logic brPlain = (coef.offBSign == 1'b0) && (coef.offB == 14'h0000) && (sotBridge == '0);
  property p_bridge_unit;
    rawValid && coef.gainB == 15'h0800 && brPlain |=>
      result_ff.bridgeCorr == $past(bridgeRawReading) && resultValid_ff;
  endproperty
  a_bridge_unit: assert property (p_bridge_unit) else $error("unit gain altered bridge");
  property p_gain_scale;
    rawValid && coef.gainB == 15'h4800 && brPlain && bridgeRawReading < 14'h0800 |=>
      result_ff.bridgeCorr == {$past(bridgeRawReading[10:0]), 3'h0};
  endproperty
  a_gain_scale: assert property (p_gain_scale) else $error("gain scale bit not x8");
  property p_gain_frac;
    rawValid && coef.gainB == 15'h0400 && brPlain |=>
      result_ff.bridgeCorr == {1'b0, $past(bridgeRawReading[13:1])};
  endproperty
  a_gain_frac: assert property (p_gain_frac) else $error("gain fraction weight wrong");
  property p_offset_neg;
    rawValid && coef.gainB == 15'h0800 && coef.offBSign && coef.offB == 14'h3FFC &&
      sotBridge == '0 && bridgeRawReading >= 14'h0004 |=>
      result_ff.bridgeCorr == $past(bridgeRawReading) - 14'h0004;
  endproperty
  a_offset_neg: assert property (p_offset_neg) else $error("signed offset wrong");
  property p_bridge_floor;
    rawValid && coef.offBSign && coef.offB == 14'h0000 |=> result_ff.bridgeCorr == 14'h0000;
  endproperty
  a_bridge_floor: assert property (p_bridge_floor) else $error("negative bridge wrapped");
  property p_temp_unit;
    rawValid && coef.gainT == 8'h80 && coef.offT == 8'h00 |=>
      result_ff.tempCorr == {$past(tempRawReading[13:2]), 2'h0};
  endproperty
  a_temp_unit: assert property (p_temp_unit) else $error("temperature gain or step wrong");
  property p_temp_off;
    rawValid && coef.gainT == 8'h00 |=>
      result_ff.tempCorr == ($past(coef.offT[7]) ? 14'h0000 : {6'h00, $past(coef.offT)});
  endproperty
  a_temp_off: assert property (p_temp_off) else $error("temperature offset wrong");
  property p_ref_temp;
    rawValid && tempRawReading[13:7] == coef.refTemp |=>
      result_ff.offDrift == 16'h0000 && result_ff.gainDrift == 16'h0000;
  endproperty
  a_ref_temp: assert property (p_ref_temp) else $error("drift nonzero at reference");
  property p_tco_scale;
    coef.driftCfg == 3'h2 |-> tcoS == $signed({1'b0, coef.tcoMag, 3'h0});
  endproperty
  a_tco_scale: assert property (p_tco_scale) else $error("offset drift scale wrong");
  property p_tco_sign;
    coef.driftCfg[1:0] == 2'h1 |-> tcoS == -$signed({4'h0, coef.tcoMag});
  endproperty
  a_tco_sign: assert property (p_tco_sign) else $error("offset drift sign wrong");
  property p_tcg_sign;
    coef.driftCfg[DRIFT_TCO_SCALE] |-> tcgS == (coef.driftCfg[DRIFT_TCG_SIGN] ?
      -$signed({4'h0, coef.tcgMag}) : $signed({4'h0, coef.tcgMag}));
  endproperty
  a_tcg_sign: assert property (p_tcg_sign) else $error("gain drift sign or scale wrong");
  property p_sot_one;
    $onehot0({sotBridge != '0, sotTcg != '0, sotTco != '0}) &&
      (coef.sotSel != 2'h3 || sotS == '0 || (sotBridge == '0 && sotTcg == '0 && sotTco == '0));
  endproperty
  a_sot_one: assert property (p_sot_one) else $error("second-order term on two targets");
  property p_sot_tco8;
    coef.sotSel == SOT_TO_TCO && coef.driftCfg[DRIFT_TCO_SCALE] && coef.sotCoef[7] |->
      sotTco == -$signed({2'h0, coef.sotCoef[6:0], 3'h0});
  endproperty
  a_sot_tco8: assert property (p_sot_tco8) else $error("second-order drift scale wrong");
  property p_clip_sticky;
    rawValid && clipNow[1] |=> statFlag_ff[1] ##1 (statFlag_ff[1] || $past(statClear[1]));
  endproperty
  a_clip_sticky: assert property (p_clip_sticky) else $error("clip flag lost");
  c_scaled_gain: cover property (rawValid && coef.gainB[GAINB_SCALE_BIT]);
  c_sot_tco_scaled: cover property (rawValid && sotScale && sotTco != '0);
  c_bridge_clip: cover property (rawValid && clipNow[1]);
  c_write_resp: cover property (bDone && bResp_ff == RESP_OKAY);
endmodule : ccd_core
`default_nettype wire

// ==== design/ccd_pkg.sv ====
// package: constants, register map and carrier types of the calibration coefficient decoder
// Notes on behaviour
// - bridge reading unsigned 0..16383, step one
// - temperature reading unsigned 0..16383, step four
// - bridge gain bit 14 multiplies value by eight
// - bridge gain bits 13:0 fixed point, bit13=4
// - sign bit prefixed makes 15-bit two's complement offset
// - temperature gain fixed point, bit 7 weighs one
// - temperature offset is 8-bit two's complement
// - reference temperature is upper seven raw bits
// - offset drift: magnitude, sign bit0, scale bit1
// - offset drift scale flag multiplies by eight
// - gain drift: magnitude, sign bit2, no scale
// - second-order term hits the one selected target, none for code 11
// - offset-drift second-order term also scaled by eight
// - bridge nonlinearity saturates beyond negative limit
// - second-order coefficient is sign-magnitude, seven-bit magnitude
package ccd_pkg;
  localparam int unsigned AXI_AW = 8;
  localparam int unsigned AXI_DW = 32;
  localparam int unsigned RAW_W = 14;
  localparam int unsigned GAINB_W = 15;
  localparam int unsigned GAINB_SCALE_BIT = 14;
  localparam int unsigned GAINB_FRAC = 11;
  localparam int unsigned GAINB_SCALE_SH = 3;
  localparam int unsigned GAIN_DEC_W = 17;
  localparam int unsigned OFFB_W = 14;
  localparam int unsigned COEF8_W = 8;
  localparam int unsigned GAINT_FRAC = 7;
  localparam int unsigned TEMP_STEP_SH = 2;
  localparam int unsigned REFT_W = 7;
  localparam int unsigned REFT_SH = 7;
  localparam int unsigned SCALED_W = 12;
  localparam int unsigned DRIFT_SCALE_SH = 3;
  localparam int unsigned SOT_MAG_W = 7;
  localparam int unsigned NL_SH = 14;
  localparam int unsigned SOT_BR_SH = 9;
  localparam int unsigned DRIFT_W = 16;
  // drift sign/scale field bits
  localparam int unsigned DRIFT_TCO_SIGN = 0;
  localparam int unsigned DRIFT_TCO_SCALE = 1;
  localparam int unsigned DRIFT_TCG_SIGN = 2;
  // second-order target codes
  localparam logic [1:0] SOT_TO_BRIDGE = 2'h0;
  localparam logic [1:0] SOT_TO_TCG = 2'h1;
  localparam logic [1:0] SOT_TO_TCO = 2'h2;
  // register byte offsets
  localparam logic [AXI_AW-1:0] REG_GAIN_B = 8'h00;
  localparam logic [AXI_AW-1:0] REG_OFFSET_B = 8'h04;
  localparam logic [AXI_AW-1:0] REG_TEMP_COEF = 8'h08;
  localparam logic [AXI_AW-1:0] REG_DRIFT = 8'h0C;
  localparam logic [AXI_AW-1:0] REG_SECOND = 8'h10;
  localparam logic [AXI_AW-1:0] REG_STATUS = 8'h14;
  localparam logic [AXI_AW-1:0] REG_BRIDGE_OUT = 8'h18;
  localparam logic [AXI_AW-1:0] REG_TEMP_OUT = 8'h1C;
  localparam logic [AXI_AW-1:0] REG_OFF_DRIFT = 8'h20;
  localparam logic [AXI_AW-1:0] REG_GAIN_DRIFT = 8'h24;
  localparam int unsigned NUM_COEF = 5;
  localparam int unsigned NUM_CLIP = 5;
  // field positions inside coefficient words
  localparam int unsigned OFFB_SIGN_BIT = 14;
  localparam int unsigned GAINT_LSB = 0;
  localparam int unsigned OFFT_LSB = 8;
  localparam int unsigned REFT_LSB = 16;
  localparam int unsigned TCO_LSB = 0;
  localparam int unsigned TCG_LSB = 8;
  localparam int unsigned DCFG_LSB = 16;
  localparam int unsigned SOT_LSB = 0;
  localparam int unsigned SEL_LSB = 8;
  localparam logic [AXI_DW-1:0] COEF_MASK [NUM_COEF] = '{
    32'h00007FFF, 32'h00007FFF, 32'h007FFFFF, 32'h0007FFFF, 32'h000003FF};
  localparam logic [AXI_DW-1:0] COEF_RESET = 32'h00000000;
  localparam logic [NUM_CLIP-1:0] STAT_RESET = 5'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [GAINB_W-1:0] gainB;
    logic offBSign;
    logic [OFFB_W-1:0] offB;
    logic [COEF8_W-1:0] gainT;
    logic [COEF8_W-1:0] offT;
    logic [REFT_W-1:0] refTemp;
    logic [COEF8_W-1:0] tcoMag;
    logic [COEF8_W-1:0] tcgMag;
    logic [2:0] driftCfg;
    logic [COEF8_W-1:0] sotCoef;
    logic [1:0] sotSel;
  } ccd_coef_t;

  typedef struct packed {
    logic [RAW_W-1:0] bridgeCorr;
    logic [RAW_W-1:0] tempCorr;
    logic [DRIFT_W-1:0] offDrift;
    logic [DRIFT_W-1:0] gainDrift;
  } ccd_result_t;
endpackage : ccd_pkg

// ==== design/ccd_sat.sv ====
// saturating narrowing of a signed value to a signed or unsigned range
`timescale 1ns/100ps
`default_nettype none
module ccd_sat #(
  parameter int IN_W = 32,
  parameter int OUT_W = 14,
  parameter bit UNS = 1'b1
) (
  input wire logic signed [IN_W-1:0] din,
  output logic [OUT_W-1:0] dout,
  output logic clipped
);
  localparam logic signed [IN_W-1:0] ONE = IN_W'(1);
  localparam logic signed [IN_W-1:0] MAXV = UNS ? (ONE <<< OUT_W) - ONE :
                                                  (ONE <<< (OUT_W - 1)) - ONE;
  localparam logic signed [IN_W-1:0] MINV = UNS ? '0 : -(ONE <<< (OUT_W - 1));

  wire logic overHi = din > MAXV;
  wire logic underLo = din < MINV;

  // clamp instead of wrap so a runaway term pins to the rail
  assign dout = overHi ? MAXV[OUT_W-1:0] : (underLo ? MINV[OUT_W-1:0] : din[OUT_W-1:0]);
  assign clipped = overHi | underLo;
endmodule : ccd_sat
`default_nettype wire

// ==== design/ccd_sm_scale.sv ====
// sign-magnitude coefficient to signed operand with optional times-eight scale
`timescale 1ns/100ps
`default_nettype none
module ccd_sm_scale (
  input wire logic negative,
  input wire logic [ccd_pkg::COEF8_W-1:0] magnitude,
  input wire logic scaleBy8,
  output logic signed [ccd_pkg::SCALED_W-1:0] value
);
  import ccd_pkg::*;

  wire logic signed [SCALED_W-1:0] magExt = $signed({{(SCALED_W - COEF8_W){1'b0}}, magnitude});
  wire logic signed [SCALED_W-1:0] signedVal = negative ? -magExt : magExt;

  // 255 * 8 still fits, so the shift never overflows
  assign value = scaleBy8 ? (signedVal <<< DRIFT_SCALE_SH) : signedVal;
endmodule : ccd_sm_scale
`default_nettype wire

// ==== testbench/ccd_host_model.sv ====
// calibration host model: axi-lite master that loads coefficients
`timescale 1ns/100ps
`default_nettype none
module ccd_host_model (
  input wire logic ref_clk,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // the caller supplies the values; these tasks only run the bus handshakes
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) bready <= 1'b0;
    end while (!bvalid);
    r = bresp;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) rready <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
  endtask : rd
endmodule : ccd_host_model
`default_nettype wire

// ==== testbench/test_calibration_coefficient_decode.sv ====
// self-checking bench for the coefficient decoder
`timescale 1ns/100ps
`default_nettype none
module test_calibration_coefficient_decode;
  import ccd_pkg::*;
  logic ref_clk, rst_n, rawValid;
  logic [RAW_W-1:0] bRaw, tRaw;
  wire [7:0] awaddr, araddr;
  wire [31:0] wdata, rdata;
  wire [1:0] bresp, rresp;
  wire awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  ccd_result_t corrected;
  wire correctedValid;
  int failures = 0;
  int n_checks = 0;
  ccd_core dut (.ref_clk(ref_clk), .rst_n(rst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .bridgeRawReading(bRaw), .tempRawReading(tRaw), .rawValid(rawValid),
    .corrected(corrected), .correctedValid(correctedValid));
  ccd_host_model host (.*);
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    host.wr(a, d, r);
    chk(32'(r), 32'(RESP_OKAY));
  endtask : w
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    host.rd(a, d, r);
    chk(d, e);
    chk(32'(r), 32'(er));
  endtask : rchk
  // one sample; result lands one cycle after the strobe
  task automatic samp(input logic [13:0] b, input logic [13:0] t);
    @(posedge ref_clk);
    bRaw <= b;
    tRaw <= t;
    rawValid <= 1'b1;
    @(posedge ref_clk);
    rawValid <= 1'b0;
    #1;
    chk(32'(correctedValid), 32'h1);
  endtask : samp
  task automatic t_regs();
    logic [1:0] r;
    chk(32'(correctedValid), 32'h0);
    rchk(REG_GAIN_B, 32'h0, RESP_OKAY);
    w(REG_GAIN_B, 32'hFFFF_FFFF);
    rchk(REG_GAIN_B, 32'h0000_7FFF, RESP_OKAY);
    host.wr(REG_BRIDGE_OUT, 32'h1, r);
    chk(32'(r), 32'(RESP_SLVERR));
    rchk(8'h40, 32'h0, RESP_SLVERR);
  endtask : t_regs
  task automatic t_bridge();
    w(REG_GAIN_B, 32'h0000_0800);
    w(REG_OFFSET_B, 32'h0000_7FFC);
    samp(14'h3E8, 14'h0);
    chk(32'(corrected.bridgeCorr), 32'h3E4);
    samp(14'h0, 14'h0);
    chk(32'(corrected.bridgeCorr), 32'h0);
    w(REG_GAIN_B, 32'h0000_4100);
    w(REG_OFFSET_B, 32'h0);
    samp(14'h1388, 14'h0);
    chk(32'(corrected.bridgeCorr), 32'h1388);
    w(REG_GAIN_B, 32'h0000_0800);
    w(REG_SECOND, 32'h0000_007F);
    samp(14'h2000, 14'h0);
    chk(32'(corrected.bridgeCorr), 32'h23F8);
    w(REG_SECOND, 32'h0000_00FF);
    samp(14'h2000, 14'h0);
    chk(32'(corrected.bridgeCorr), 32'h1C08);
    w(REG_SECOND, 32'h0000_007F);
    samp(14'h3FFF, 14'h0);
    chk(32'(corrected.bridgeCorr), 32'h3FFF);
    rchk(REG_STATUS, 32'h0000_0003, RESP_OKAY);
    w(REG_STATUS, 32'h0000_0003);
    rchk(REG_STATUS, 32'h0, RESP_OKAY);
  endtask : t_bridge
  task automatic t_drift();
    w(REG_TEMP_COEF, 32'h001E_D780);
    w(REG_DRIFT, 32'h0003_0705);
    w(REG_SECOND, 32'h0000_0283);
    samp(14'h0, 14'h1003);
    chk(32'(corrected.tempCorr), 32'h0FD7);
    chk(32'(corrected.offDrift), 32'hFF50);
    chk(32'(corrected.gainDrift), 32'h000E);
    w(REG_SECOND, 32'h0000_0183);
    samp(14'h0, 14'h1003);
    chk(32'(corrected.offDrift), 32'hFFB0);
    chk(32'(corrected.gainDrift), 32'h0002);
    w(REG_DRIFT, 32'h0004_0705);
    w(REG_SECOND, 32'h0000_0305);
    samp(14'h0, 14'h1003);
    chk(32'(corrected.offDrift), 32'h000A);
    chk(32'(corrected.gainDrift), 32'hFFF2);
  endtask : t_drift
  task automatic conclude();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  // watchdog: the tests need well under a tenth of this span
  initial begin
    #200000;
    failures++;
    conclude();
  end
  initial begin
    {rst_n, rawValid, bRaw, tRaw} = '0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs();
    t_bridge();
    t_drift();
    conclude();
  end
endmodule : test_calibration_coefficient_decode
`default_nettype wire
